// >>> core/tmrps_defines.svh
// constants, offsets and bit positions of the timer prescale block
// Behaviour
// - type A ratios 1,8,64,256 on bits 5:4
// - type B eight ratios on bits 6:4
// - prescaler cleared on count write, disable, reset
// - disabled timer stops and draws no ticks
// - period writable while running, software avoids it
// - low byte write keeps high, carries normally
// - high byte write keeps low, carries normally
// - count write masks that cycle's increment
// - disabling holds the count value
// - synchronous modes access registers without delay
// - async count read lags two bus clocks
// - async count write lands after input ticks
// - type A external source starts after input clock edges
// - type B enable and access zero latency
// - sync flag one bus plus two clocks
// - async flag half input cycle plus two
// - type A: enabled secondary oscillator replaces external pin
// - oscillator enable bit 1, fuse bit 5 low
// - match returns count to zero, zero period sticks
`ifndef TMRPS_DEFINES_SVH
`define TMRPS_DEFINES_SVH
`define TMRPS_OFF_CTRL 5'h00
`define TMRPS_OFF_COUNT 5'h04
`define TMRPS_OFF_PERIOD 5'h08
`define TMRPS_OFF_OSC 5'h0C
`define TMRPS_OFF_STAT 5'h10
`define TMRPS_OFF_CFG 5'h14
`define TMRPS_ON_BIT 15
`define TMRPS_SYNC_BIT 2
`define TMRPS_TCS_BIT 1
`define TMRPS_PSA_HI 5
`define TMRPS_PSA_LO 4
`define TMRPS_PSB_HI 6
`define TMRPS_PSB_LO 4
`define TMRPS_OSC_EN_BIT 1
`define TMRPS_FUSE_BIT 5
`define TMRPS_FLAG_BIT 0
`define TMRPS_PEND_BIT 1
`define TMRPS_RUN_BIT 2
`define TMRPS_CTRL_RST 16'h0000
`define TMRPS_COUNT_RST 16'h0000
`define TMRPS_PERIOD_RST 16'hFFFF
`define TMRPS_SH_1 4'h0
`define TMRPS_SH_2 4'h1
`define TMRPS_SH_4 4'h2
`define TMRPS_SH_8 4'h3
`define TMRPS_SH_16 4'h4
`define TMRPS_SH_32 4'h5
`define TMRPS_SH_64 4'h6
`define TMRPS_SH_256 4'h8
`define TMRPS_ASYNC_WR_LAST 2'h1
`define TMRPS_EXT_START_LAST 2'h1
`define TMRPS_RESP_OKAY 2'h0
`define TMRPS_RESP_SLVERR 2'h2
`endif

// >>> core/tmrps_pkg.sv
// types shared by the timer prescale block
package tmrps_pkg;
	typedef enum logic [1:0] {st_off, st_arm, st_run} tmrps_state_t;
	typedef struct packed {
		logic on;
		logic sync;
		logic tcs;
		logic [2:0] ps;
	} tmrps_ctrl_t;
	typedef struct packed {
		logic [15:0] count;
		logic flag;
		logic wr_pending;
	} tmrps_stat_t;
endpackage : tmrps_pkg

// >>> core/tmrps_prescaler.sv
// input clock prescaler producing one count enable per ratio ticks
`timescale 1ns/100ps
`default_nettype none
module tmrps_prescaler (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic tick,
	input wire logic [3:0] shift,
	output logic pulse
);
	logic [7:0] cnt_q;
	logic [7:0] limit;

	// ratio minus one; shift of 8 gives 255
	assign limit = 8'((9'h001 << shift) - 9'h001);
	assign pulse = tick && (cnt_q == limit);

	// clear beats tick so a write restarts the ratio cleanly
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
		end else if (clr) begin
			cnt_q <= 8'h00;
		end else if (tick) begin
			cnt_q <= pulse ? 8'h00 : cnt_q + 8'h01;
		end
	end

	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);

	ps_clear_a: assert property (clr |=> cnt_q == 8'h00)
		else $error("prescaler not cleared");
	ps_pulse_a: assert property (pulse |=> cnt_q == 8'h00)
		else $error("prescaler pulse off ratio");
endmodule : tmrps_prescaler
`default_nettype wire

// >>> core/tmrps_top.sv
// timer core with prescaler, count/period registers and AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "tmrps_defines.svh"
module tmrps_top #(
	parameter bit TYPE_A = 1'b1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic soft_reset,
	input wire logic ext_clk_pin,
	input wire logic sosc_clk,
	input wire logic [7:0] device_config_word,
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output tmrps_pkg::tmrps_stat_t timer_status
);
	import tmrps_pkg::*;

	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [4:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, rd_val;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_go, rd_go, rd_err, wr_err;
	logic [15:0] ctrl_q, count_q, period_q, cnt_s1_q, cnt_s2_q;
	logic [15:0] pend_val_q;
	logic [1:0] pend_be_q, pend_cnt_q, arm_cnt_q, dly_q;
	logic osc_en_q, pend_q, flag_q, half_q, src_q;
	tmrps_state_t st_q;
	tmrps_ctrl_t ctl;
	logic async_mode, sosc_active, pin_now, rise, fall, raw_tick;
	logic running, tick_en, pulse, ps_clr, at_period, match_ev;
	logic wr_cnt, wr_cnt_now, wr_cnt_late, land, flag_in, flag_tap;
	logic [3:0] ps_shift;

	// byte lane merge used by every 16-bit register write
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nv, input logic [1:0] be);
		merge16 = {be[1] ? nv[15:8] : old[15:8], be[0] ? nv[7:0] : old[7:0]};
	endfunction : merge16

	// write address and data are taken in either order, answered together
	assign awready = !aw_full_q;
	assign wready = !w_full_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_q <= 1'b0;
			awaddr_q <= 5'h00;
		end else if (awvalid && !aw_full_q) begin
			aw_full_q <= 1'b1;
			awaddr_q <= awaddr;
		end else if (wr_go) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			w_full_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (wvalid && !w_full_q) begin
			w_full_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (wr_go) begin
			w_full_q <= 1'b0;
		end
	end

	// unmapped addresses answer slave error and change nothing
	always_comb begin
		case (awaddr_q)
		`TMRPS_OFF_CTRL, `TMRPS_OFF_COUNT, `TMRPS_OFF_PERIOD,
		`TMRPS_OFF_OSC, `TMRPS_OFF_STAT, `TMRPS_OFF_CFG: wr_err = 1'b0;
		default: wr_err = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= `TMRPS_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_err ? `TMRPS_RESP_SLVERR : `TMRPS_RESP_OKAY;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read channel answers one cycle after the address is taken
	assign arready = !rvalid_q;
	assign rd_go = arvalid && !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	always_comb begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		case (araddr)
		`TMRPS_OFF_CTRL: rd_val[15:0] = ctrl_q;
		`TMRPS_OFF_COUNT: rd_val[15:0] = async_mode ? cnt_s2_q : count_q;
		`TMRPS_OFF_PERIOD: rd_val[15:0] = period_q;
		`TMRPS_OFF_OSC: rd_val[`TMRPS_OSC_EN_BIT] = osc_en_q;
		`TMRPS_OFF_STAT: begin
			rd_val[`TMRPS_FLAG_BIT] = flag_q;
			rd_val[`TMRPS_PEND_BIT] = pend_q;
			rd_val[`TMRPS_RUN_BIT] = running;
		end
		`TMRPS_OFF_CFG: rd_val[7:0] = device_config_word;
		default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `TMRPS_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_err ? `TMRPS_RESP_SLVERR : `TMRPS_RESP_OKAY;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// control fields; the hardware does not guard against changing
	// them while running, software disables first
	assign ctl.on = ctrl_q[`TMRPS_ON_BIT];
	assign ctl.sync = ctrl_q[`TMRPS_SYNC_BIT];
	assign ctl.tcs = ctrl_q[`TMRPS_TCS_BIT];
	assign ctl.ps = TYPE_A ? {1'b0, ctrl_q[`TMRPS_PSA_HI:`TMRPS_PSA_LO]}
		: ctrl_q[`TMRPS_PSB_HI:`TMRPS_PSB_LO];

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `TMRPS_CTRL_RST;
		end else if (wr_go && awaddr_q == `TMRPS_OFF_CTRL) begin
			ctrl_q <= merge16(ctrl_q, wdata_q[15:0], wstrb_q[1:0]);
		end
	end

	// period accepted at any time, even while counting
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			period_q <= `TMRPS_PERIOD_RST;
		end else if (wr_go && awaddr_q == `TMRPS_OFF_PERIOD) begin
			period_q <= merge16(period_q, wdata_q[15:0], wstrb_q[1:0]);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			osc_en_q <= 1'b0;
		end else if (wr_go && awaddr_q == `TMRPS_OFF_OSC && wstrb_q[0]) begin
			osc_en_q <= wdata_q[`TMRPS_OSC_EN_BIT];
		end
	end

	// ratio decode per variant
	always_comb begin
		ps_shift = `TMRPS_SH_1;
		if (TYPE_A) begin
			case (ctl.ps[1:0])
			2'h0: ps_shift = `TMRPS_SH_1;
			2'h1: ps_shift = `TMRPS_SH_8;
			2'h2: ps_shift = `TMRPS_SH_64;
			default: ps_shift = `TMRPS_SH_256;
			endcase
		end else begin
			case (ctl.ps)
			3'h0: ps_shift = `TMRPS_SH_1;
			3'h1: ps_shift = `TMRPS_SH_2;
			3'h2: ps_shift = `TMRPS_SH_4;
			3'h3: ps_shift = `TMRPS_SH_8;
			3'h4: ps_shift = `TMRPS_SH_16;
			3'h5: ps_shift = `TMRPS_SH_32;
			3'h6: ps_shift = `TMRPS_SH_64;
			default: ps_shift = `TMRPS_SH_256;
			endcase
		end
	end

	// source select; the fuse bit must read low for the oscillator
	assign sosc_active = TYPE_A && osc_en_q && !device_config_word[`TMRPS_FUSE_BIT];
	assign pin_now = (sosc_active && ctl.tcs) ? sosc_clk : ext_clk_pin;
	assign rise = pin_now && !src_q;
	assign fall = !pin_now && src_q;
	assign async_mode = TYPE_A && ctl.tcs && !ctl.sync;
	assign raw_tick = ctl.tcs ? rise : 1'b1;

	// a switch of source may show one spurious edge; disable first
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			src_q <= 1'b0;
		end else begin
			src_q <= pin_now;
		end
	end

	// start sequencer: external clocking on type A waits for input edges
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= st_off;
			arm_cnt_q <= 2'h0;
		end else begin
			case (st_q)
			st_off: begin
				arm_cnt_q <= 2'h0;
				if (ctl.on) begin
					st_q <= (TYPE_A && ctl.tcs) ? st_arm : st_run;
				end
			end
			st_arm: begin
				if (!ctl.on) begin
					st_q <= st_off;
				end else if (rise) begin
					if (arm_cnt_q == `TMRPS_EXT_START_LAST) begin
						st_q <= st_run;
					end else begin
						arm_cnt_q <= arm_cnt_q + 2'h1;
					end
				end
			end
			st_run: begin
				if (!ctl.on) begin
					st_q <= st_off;
				end
			end
			default: st_q <= st_off;
			endcase
		end
	end

	// internal clocking starts the same cycle the enable is seen
	assign running = ctl.on && (st_q == st_run || !(TYPE_A && ctl.tcs));
	assign tick_en = running && raw_tick;
	assign ps_clr = wr_cnt || !ctl.on || soft_reset;

	tmrps_prescaler u_prescaler (
		.core_clk(core_clk),
		.nrst(nrst),
		.clr(ps_clr),
		.tick(tick_en),
		.shift(ps_shift),
		.pulse(pulse)
	);

	// count writes: immediate when synchronous, deferred when async
	assign wr_cnt = wr_go && awaddr_q == `TMRPS_OFF_COUNT && wstrb_q[1:0] != 2'h0;
	assign wr_cnt_now = wr_cnt && !async_mode;
	assign wr_cnt_late = wr_cnt && async_mode && !pend_q;
	assign land = pend_q && rise && pend_cnt_q == `TMRPS_ASYNC_WR_LAST;

	// a second async write while one is in flight is dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 1'b0;
			pend_cnt_q <= 2'h0;
			pend_val_q <= `TMRPS_COUNT_RST;
			pend_be_q <= 2'h0;
		end else if (wr_cnt_late) begin
			pend_q <= 1'b1;
			pend_cnt_q <= 2'h0;
			pend_val_q <= wdata_q[15:0];
			pend_be_q <= wstrb_q[1:0];
		end else if (land) begin
			pend_q <= 1'b0;
		end else if (pend_q && rise) begin
			pend_cnt_q <= pend_cnt_q + 2'h1;
		end
	end

	// the counter; untouched lanes keep their bytes so carries flow
	assign at_period = count_q == period_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= `TMRPS_COUNT_RST;
		end else if (wr_cnt_now) begin
			count_q <= merge16(count_q, wdata_q[15:0], wstrb_q[1:0]);
		end else if (land) begin
			count_q <= merge16(count_q, pend_val_q, pend_be_q);
		end else if (pulse) begin
			count_q <= at_period ? `TMRPS_COUNT_RST : count_q + 16'h0001;
		end
	end

	// two-stage read path for the async clocking case
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_s1_q <= `TMRPS_COUNT_RST;
			cnt_s2_q <= `TMRPS_COUNT_RST;
		end else begin
			cnt_s1_q <= count_q;
			cnt_s2_q <= cnt_s1_q;
		end
	end

	// match event; a zero period never raises the flag
	assign match_ev = pulse && at_period && period_q != `TMRPS_COUNT_RST
		&& !wr_cnt_now && !land;
	assign flag_in = async_mode ? (half_q && fall) : match_ev;
	assign flag_tap = async_mode ? dly_q[0] : dly_q[1];

	// async events wait for the next falling input edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			half_q <= 1'b0;
			dly_q <= 2'h0;
		end else begin
			dly_q <= {dly_q[0], flag_in};
			if (async_mode && match_ev) begin
				half_q <= 1'b1;
			end else if (fall || !async_mode) begin
				half_q <= 1'b0;
			end
		end
	end

	// sticky flag, write one to clear; a new event beats the clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flag_q <= 1'b0;
		end else if (flag_tap) begin
			flag_q <= 1'b1;
		end else if (wr_go && awaddr_q == `TMRPS_OFF_STAT && wstrb_q[0]
			&& wdata_q[`TMRPS_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	assign timer_status.count = count_q;
	assign timer_status.flag = flag_q;
	assign timer_status.wr_pending = pend_q;

	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_sync_match;
		match_ev && !async_mode;
	endsequence
	sequence s_flag_rise;
		!flag_q ##1 !flag_q ##1 flag_q;
	endsequence

	cnt_hold_a: assert property (!ctl.on && !wr_cnt_now && !land |=> $stable(count_q))
		else $error("count moved while disabled");
	pwr_down_a: assert property (!ctl.on |-> !tick_en && !pulse)
		else $error("ticks while disabled");
	lo_byte_a: assert property (wr_cnt_now && wstrb_q[1:0] == 2'h1
		|=> count_q[15:8] == $past(count_q[15:8]))
		else $error("low byte write disturbed high byte");
	hi_byte_a: assert property (wr_cnt_now && wstrb_q[1:0] == 2'h2
		|=> count_q[7:0] == $past(count_q[7:0]))
		else $error("high byte write disturbed low byte");
	wr_mask_a: assert property (wr_cnt_now && wstrb_q[1:0] == 2'h3
		|=> count_q == $past(wdata_q[15:0]))
		else $error("increment not masked on write");
	rd_lag_a: assert property (rd_go && async_mode && araddr == `TMRPS_OFF_COUNT
		|=> rdata_q == $past(count_q, 3))
		else $error("async read lag wrong");
	rd_now_a: assert property (rd_go && !async_mode && araddr == `TMRPS_OFF_COUNT
		|=> rdata_q == $past(count_q))
		else $error("sync read not immediate");
	wrap_a: assert property (pulse && at_period && !wr_cnt_now && !land
		|=> count_q == `TMRPS_COUNT_RST)
		else $error("count did not wrap at period");
	flag_sync_a: assert property (s_sync_match ##0 (!flag_q && dly_q == 2'h0) |-> ##1 s_flag_rise)
		else $error("sync flag latency wrong");
	flag_async_a: assert property (async_mode && half_q && fall
		|-> ##2 flag_q)
		else $error("async flag latency wrong");
	start_a: assert property (st_q == st_arm |-> !tick_en)
		else $error("counted before start edges");
	land_a: assert property (wr_cnt_late ##1 (!rise [*2]) |-> ##0 pend_q)
		else $error("async write landed early");
	zero_per_a: assert property (period_q == `TMRPS_COUNT_RST && count_q == `TMRPS_COUNT_RST
		&& !wr_cnt_now && !land |=> count_q == `TMRPS_COUNT_RST && !match_ev)
		else $error("zero period moved the count");
endmodule : tmrps_top
`default_nettype wire

// >>> sim/tmrps_axi_host.sv
// AXI4-Lite host model standing in for processor software
`timescale 1ns/100ps
`default_nettype none
module tmrps_axi_host (
	input wire logic core_clk,
	output logic [4:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [4:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// idle bus from time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr} = 10'h000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
	end

	// address and data offered together; payload scrambled once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// rready held from the start, data taken at the rvalid edge
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : tmrps_axi_host
`default_nettype wire

// >>> sim/test_timer_prescale_write_latency.sv
// self-checking bench for the timer prescale block
`timescale 1ns/100ps
`default_nettype none
`include "tmrps_defines.svh"
module test_timer_prescale_write_latency;
	import tmrps_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic soft_reset = 1'b0;
	logic ext_clk_pin = 1'b0;
	logic sosc_clk = 1'b0;
	logic [7:0] device_config_word = 8'h00;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, v2;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	tmrps_stat_t timer_status;
	int fails = 0;
	int n_compared = 0;
	int c;
	int ratio[4] = '{1, 8, 64, 256};
	int ratio_b[4] = '{1, 2, 4, 8};
	tmrps_stat_t status_b;

	always #20 core_clk = ~core_clk;

	tmrps_top #(.TYPE_A(1'b1)) uut (.core_clk(core_clk), .nrst(nrst), .soft_reset(soft_reset),
		.ext_clk_pin(ext_clk_pin), .sosc_clk(sosc_clk), .device_config_word(device_config_word),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .timer_status(timer_status));

	tmrps_axi_host host (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// sync-only variant on the same bus; its bus timing matches the first cycle for cycle
	tmrps_top #(.TYPE_A(1'b0)) uut_b (.core_clk(core_clk), .nrst(nrst), .soft_reset(soft_reset),
		.ext_clk_pin(ext_clk_pin), .sosc_clk(sosc_clk), .device_config_word(device_config_word),
		.awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(),
		.rvalid(), .rready(rready), .timer_status(status_b));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		host.rd(a, v, resp);
		check(v, exp);
	endtask : rdc

	// stop first, change fields, then start in a separate write
	task automatic run(input logic [31:0] ctl);
		host.wr(`TMRPS_OFF_CTRL, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_CTRL, ctl, 4'hF, resp);
		host.wr(`TMRPS_OFF_CTRL, ctl | 32'h00008000, 4'hF, resp);
	endtask : run

	// edges until the live count moves; bounded so a dead counter cannot hang
	task automatic wait_move(output int n);
		logic [15:0] old;
		old = timer_status.count;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (timer_status.count === old && n < 1000);
	endtask : wait_move

	// same measure on the sync-only variant
	task automatic wait_move_b(output int n);
		logic [15:0] old;
		old = status_b.count;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (status_b.count === old && n < 1000);
	endtask : wait_move_b

	task automatic peak(input logic [15:0] exp);
		logic [15:0] top;
		top = 16'h0000;
		repeat (40) begin
			@(posedge core_clk);
			if (timer_status.count > top) top = timer_status.count;
		end
		check(top, exp);
	endtask : peak

	// slow source edges; the source stands low between bursts
	task automatic edges(input bit osc, input int n);
		repeat (n) begin
			@(posedge core_clk);
			if (osc) sosc_clk <= 1'b1; else ext_clk_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
			if (osc) sosc_clk <= 1'b0; else ext_clk_pin <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask : edges

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	// watchdog: the whole sequence needs well under this span
	initial begin
		repeat (40000) @(posedge core_clk);
		fails++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		rdc(`TMRPS_OFF_CTRL, 32'h00000000);
		rdc(`TMRPS_OFF_PERIOD, 32'h0000FFFF);
		rdc(5'h18, 32'h00000000);
		check(resp, `TMRPS_RESP_SLVERR);
		host.wr(5'h18, 32'h00000001, 4'hF, resp);
		check(resp, `TMRPS_RESP_SLVERR);
		$display("test access done");
		// spacing between count steps equals the selected ratio
		for (int p = 0; p < 4; p++) begin
			run({26'h0, p[1:0], 4'h0});
			wait_move(c);
			wait_move(c);
			check(c, ratio[p]);
			wait_move_b(c);
			wait_move_b(c);
			check(c, ratio_b[p]);
		end
		host.wr(`TMRPS_OFF_CTRL, 32'h00000030, 4'hF, resp);
		host.rd(`TMRPS_OFF_COUNT, v2, resp);
		repeat (300) @(posedge core_clk);
		rdc(`TMRPS_OFF_COUNT, v2);
		$display("test ratios done");
		// a count write restarts the ratio from zero and drops its own step
		run(32'h00000010);
		host.wr(`TMRPS_OFF_COUNT, 32'h00001234, 4'hF, resp);
		repeat (3) @(posedge core_clk);
		check(timer_status.count, 32'h00001234);
		repeat (9) @(posedge core_clk);
		check(timer_status.count, 32'h00001235);
		run(32'h00000030);
		host.wr(`TMRPS_OFF_COUNT, 32'h00001200, 4'hF, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h000000FF, 4'h1, resp);
		rdc(`TMRPS_OFF_COUNT, 32'h000012FF);
		wait_move(c);
		check(timer_status.count, 32'h00001300);
		host.wr(`TMRPS_OFF_COUNT, 32'h000000FF, 4'h1, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h00005600, 4'h2, resp);
		rdc(`TMRPS_OFF_COUNT, 32'h000056FF);
		wait_move(c);
		check(timer_status.count, 32'h00005700);
		// a warm reset mid-ratio must postpone the next step by a full ratio
		wait_move(c);
		repeat (200) @(posedge core_clk);
		soft_reset <= 1'b1;
		@(posedge core_clk);
		soft_reset <= 1'b0;
		wait_move(c);
		check(c > 250, 1'b1);
		$display("test count writes done");
		host.wr(`TMRPS_OFF_CTRL, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_PERIOD, 32'h00000003, 4'hF, resp);
		host.wr(`TMRPS_OFF_STAT, 32'h00000001, 4'hF, resp);
		run(32'h00000000);
		peak(16'h0003);
		host.rd(`TMRPS_OFF_STAT, v, resp);
		check(v[0], 1'b1);
		host.wr(`TMRPS_OFF_PERIOD, 32'h00000005, 4'hF, resp);
		peak(16'h0005);
		host.wr(`TMRPS_OFF_CTRL, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_PERIOD, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_STAT, 32'h00000001, 4'hF, resp);
		run(32'h00000000);
		peak(16'h0000);
		rdc(`TMRPS_OFF_STAT, 32'h00000004);
		$display("test period done");
		// pin source: two edges pass before type A counting starts, type B counts at once
		host.wr(`TMRPS_OFF_PERIOD, 32'h0000FFFF, 4'hF, resp);
		host.wr(`TMRPS_OFF_CTRL, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h00000000, 4'hF, resp);
		run(32'h00000006);
		edges(1'b0, 1);
		check(timer_status.count, 32'h00000000);
		check(status_b.count, 32'h00000001);
		edges(1'b0, 3);
		check(timer_status.count != 16'h0000, 1'b1);
		host.wr(`TMRPS_OFF_OSC, 32'h00000002, 4'hF, resp);
		v2 = {16'h0000, timer_status.count};
		edges(1'b1, 6);
		check(timer_status.count != v2[15:0], 1'b1);
		device_config_word <= 8'h20;
		v2 = {16'h0000, timer_status.count};
		edges(1'b1, 6);
		check(timer_status.count, v2);
		edges(1'b0, 4);
		check(timer_status.count != v2[15:0], 1'b1);
		$display("test sources done");
		// unsynchronised pin: a count write waits for two source edges
		run(32'h00000002);
		edges(1'b0, 2);
		host.wr(`TMRPS_OFF_COUNT, 32'h00000040, 4'hF, resp);
		host.rd(`TMRPS_OFF_STAT, v, resp);
		check(v[1], 1'b1);
		edges(1'b0, 1);
		host.rd(`TMRPS_OFF_STAT, v, resp);
		check(v[1], 1'b1);
		edges(1'b0, 1);
		repeat (4) @(posedge core_clk);
		host.rd(`TMRPS_OFF_STAT, v, resp);
		check(v[1], 1'b0);
		host.rd(`TMRPS_OFF_COUNT, v, resp);
		check(v[15:1], 15'h0020);
		$display("test async done");
		// unsynchronised match: the flag waits for the falling source edge
		host.wr(`TMRPS_OFF_CTRL, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_COUNT, 32'h00000000, 4'hF, resp);
		host.wr(`TMRPS_OFF_PERIOD, 32'h00000001, 4'hF, resp);
		host.wr(`TMRPS_OFF_STAT, 32'h00000001, 4'hF, resp);
		run(32'h00000002);
		edges(1'b0, 5);
		rdc(`TMRPS_OFF_STAT, 32'h00000005);
		$display("test async flag done");
		wrap_up();
	end
endmodule : test_timer_prescale_write_latency
`default_nettype wire
